// ==== core/rdsg_pkg.sv ====
// rdsg_pkg: constants shared by the row driver shift-gate block
// assumes a 32-bit AHB-Lite slave view and a 250 MHz hclk
package rdsg_pkg;
    localparam int unsigned ROWS_DFLT   = 32;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned FIFO_WIDTH  = 32;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_DATA    = 8'h08;
    localparam logic [7:0]  OFS_STAGES  = 8'h0C;
    localparam logic [7:0]  OFS_ROWS    = 8'h10;
    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_FORCEN = 1;
    localparam int unsigned CTRL_SERIN  = 2;
    localparam int unsigned CTRL_CLK    = 3;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0002;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [5:0]  BITS_PER_WORD = 6'h20;
    typedef enum logic [1:0] {
        RDSG_IDLE  = 2'b00,
        RDSG_LOW   = 2'b01,
        RDSG_HIGH  = 2'b10
    } rdsg_state_e;
endpackage : rdsg_pkg

// ==== core/rdsg_fifo_if.sv ====
// rdsg_fifo_if: valid/ready word stream between the bus slave and the fifo
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface rdsg_fifo_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rdsg_fifo_if

// ==== core/rdsg_fifo.sv ====
// rdsg_fifo: synchronous fifo, width and depth as parameters
// assumes depth is a power of two
`timescale 1ns/1ps
module rdsg_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    rdsg_fifo_if.snk    wr,
    rdsg_fifo_if.src    rd,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp, rp, next_wp, next_rp;
    logic         full, empty, push, pop;

    assign full     = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty    = (wp == rp);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rp[AW-1:0]];
    assign push     = wr.valid && !full;
    assign pop      = rd.ready && !empty;
    assign level    = wp - rp;

    always_comb begin
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= wr.data;
        end
    end
endmodule : rdsg_fifo

// ==== core/rdsg_top.sv ====
// rdsg_top: 32-stage serial shift register with per-row gating and cascade out
// assumes an AHB-Lite master on hclk; the serial clock is a synchronous input
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// How it works
// - 32 stages shift only on a falling edge of the serial clock.
// - first stage takes serial in, each later stage takes its predecessor.
// - each row equals stage AND enable AND ctrl CTRL_ENABLE, ORed with inverted (force_all_on_n AND ctrl CTRL_FORCEN).
// - force high with CTRL_FORCEN set: row on only with enable and CTRL_ENABLE high and its stage one.
// - force_all_on_n low turns every row on.
// - cascade output is the last stage, independent of enable and force.
// - cascade out can feed the next device's serial in on the shared edge.
// - build option reverses row output order; shifting and gating unchanged.
module rdsg_top
    import rdsg_pkg::*;
#(
    parameter int ROWS    = rdsg_pkg::ROWS_DFLT,
    parameter bit REVERSE = 1'b0
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              serial_clk,
    input  wire logic              serial_in,
    input  wire logic              enable,
    input  wire logic              force_all_on_n,
    output logic                   serial_out,
    output logic      [ROWS-1:0]   row_outputs
);
    import rdsg_pkg::*;

    // ---------------- bus slave ----------------
    logic        ap_wr, ap_rd, next_ap_wr, next_ap_rd;
    logic [7:0]  ap_addr, next_ap_addr;
    logic [31:0] ctrl, next_ctrl;
    logic [31:0] next_hrdata;
    logic        take;

    rdsg_fifo_if #(.W(FIFO_WIDTH)) fin ();
    rdsg_fifo_if #(.W(FIFO_WIDTH)) fout ();
    logic [$clog2(FIFO_DEPTH):0] fifo_level;

    rdsg_fifo #(.W(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr      (fin),
        .rd      (fout),
        .level   (fifo_level)
    );

    // data phase of a write aimed at the fifo port
    function automatic logic data_phase_wr(input logic wr, input logic [7:0] a);
        return wr && (a == OFS_DATA);
    endfunction : data_phase_wr

    assign take = hsel && hready && (htrans == HTRANS_NSEQ);
    // a data write to a full fifo waits in its data phase: back-pressure to the bus
    assign hreadyout = !(data_phase_wr(ap_wr, ap_addr) && !fin.ready);
    assign hresp     = 1'b0;
    assign fin.valid = data_phase_wr(ap_wr, ap_addr);
    assign fin.data  = hwdata;

    // ---------------- shift core ----------------
    logic [ROWS-1:0] shift_stages, next_stages;
    logic            clk_q, next_clk_q;
    logic            fall;
    logic [31:0]     word, next_word;
    logic [5:0]      bits_left, next_bits_left;
    rdsg_state_e     st, next_st;
    logic            sw_clk, sw_din;

    // the serial clock is sampled; a falling edge is a high sample then a low one
    assign fall = clk_q && !sw_clk;

    always_comb begin
        next_ap_wr   = ap_wr;
        next_ap_rd   = ap_rd;
        next_ap_addr = ap_addr;
        next_ctrl    = ctrl;
        next_hrdata  = hrdata;
        if (hreadyout) begin
            next_ap_wr   = take && hwrite;
            next_ap_rd   = take && !hwrite;
            next_ap_addr = haddr[7:0];
            if (ap_wr && ap_addr == OFS_CTRL) begin
                next_ctrl = hwdata;
            end
        end
        if (take && !hwrite) begin
            case (haddr[7:0])
                // a read right behind a ctrl write sees the value being written
                OFS_CTRL:   next_hrdata = next_ctrl;
                OFS_STATUS: next_hrdata = {24'h000000, 1'b0, fifo_level[3:0],
                                           1'b0, st};
                OFS_STAGES: next_hrdata = 32'(shift_stages);
                OFS_ROWS:   next_hrdata = 32'(row_outputs);
                default:    next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr   <= 1'b0;
            ap_rd   <= 1'b0;
            ap_addr <= 8'h00;
            ctrl    <= CTRL_RESET;
            hrdata  <= 32'h0000_0000;
        end else begin
            ap_wr   <= next_ap_wr;
            ap_rd   <= next_ap_rd;
            ap_addr <= next_ap_addr;
            ctrl    <= next_ctrl;
            hrdata  <= next_hrdata;
        end
    end

    // fifo words are played out msb first as falling edges of an internal clock
    always_comb begin
        next_st        = st;
        next_word      = word;
        next_bits_left = bits_left;
        fout.ready     = 1'b0;
        case (st)
            RDSG_IDLE: begin
                if (fout.valid) begin
                    fout.ready     = 1'b1;
                    next_word      = fout.data;
                    next_bits_left = BITS_PER_WORD;
                    next_st        = RDSG_HIGH;
                end
            end
            RDSG_HIGH: next_st = RDSG_LOW;
            RDSG_LOW: begin
                next_word      = {word[30:0], 1'b0};
                next_bits_left = bits_left - 6'h01;
                next_st        = (bits_left == 6'h01) ? RDSG_IDLE : RDSG_HIGH;
            end
            default: next_st = RDSG_IDLE;
        endcase
    end

    always_comb begin
        // fifo playback takes the serial lines while busy, else the pins and ctrl bits
        if (st != RDSG_IDLE) begin
            sw_clk = (st == RDSG_HIGH);
            sw_din = word[31];
        end else begin
            sw_clk = serial_clk | ctrl[CTRL_CLK];
            sw_din = serial_in | ctrl[CTRL_SERIN];
        end
        next_clk_q  = sw_clk;
        next_stages = shift_stages;
        if (fall) begin
            next_stages = {shift_stages[ROWS-2:0], sw_din};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st        <= RDSG_IDLE;
            word      <= 32'h0000_0000;
            bits_left <= 6'h00;
            clk_q     <= 1'b0;
        end else begin
            st        <= next_st;
            word      <= next_word;
            bits_left <= next_bits_left;
            clk_q     <= next_clk_q;
        end
    end

    // stages carry no reset, as the device itself has none
    always_ff @(posedge hclk) begin
        shift_stages <= next_stages;
    end

    // ---------------- gating ----------------
    logic            en_eff, force_n_eff;
    logic [ROWS-1:0] gated;

    assign en_eff      = enable & ctrl[CTRL_ENABLE];
    assign force_n_eff = force_all_on_n & ctrl[CTRL_FORCEN];
    assign gated       = (shift_stages & {ROWS{en_eff}}) | {ROWS{!force_n_eff}};

    always_comb begin
        for (int i = 0; i < ROWS; i++) begin
            row_outputs[i] = REVERSE ? gated[ROWS-1-i] : gated[i];
        end
    end

    assign serial_out = shift_stages[ROWS-1];

    // ---------------- checks ----------------
    // stages are undefined until a full word has gone in, so stage checks other than chk_shift_in and chk_row_follow wait for that
    localparam int FILL_W      = $clog2(ROWS) + 1;
    // one word: the pop cycle, then a high and a low cycle per bit
    localparam int PLAY_CYCLES = 2 * int'(BITS_PER_WORD) + 1;
    // a stalled write waits at most for the word in playback to finish
    localparam int STALL_MAX   = PLAY_CYCLES;
    logic [FILL_W-1:0] fill_cnt, next_fill_cnt;
    logic              filled;

    assign filled = (fill_cnt == FILL_W'(ROWS));

    always_comb begin
        next_fill_cnt = fill_cnt;
        if (fall && !filled) begin
            next_fill_cnt = fill_cnt + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fill_cnt <= '0;
        end else begin
            fill_cnt <= next_fill_cnt;
        end
    end

    chk_force_all_on: assert property (@(posedge hclk) disable iff (!hresetn)
        !force_n_eff |-> &row_outputs)
        else $error("force low but a row is off");
    chk_enable_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (force_n_eff && !en_eff) |-> (row_outputs == '0))
        else $error("enable low but a row is on");
    chk_row_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        (force_n_eff && en_eff) |->
        (REVERSE ? ((row_outputs[0] == shift_stages[ROWS-1]) &&
                    (row_outputs[ROWS-1] == shift_stages[0]))
                 : (row_outputs == shift_stages)))
        else $error("row does not follow its stage");
    chk_hold_stages: assert property (@(posedge hclk) disable iff (!hresetn)
        (filled && !fall) |=> $stable(shift_stages))
        else $error("stages changed without a falling edge");
    chk_shift_in: assert property (@(posedge hclk) disable iff (!hresetn)
        fall |=> shift_stages[0] == $past(sw_din))
        else $error("first stage missed serial in");
    chk_shift_move: assert property (@(posedge hclk) disable iff (!hresetn)
        (filled && fall) |=> shift_stages[ROWS-1:1] == $past(shift_stages[ROWS-2:0]))
        else $error("stages did not move by one");
    chk_cascade_out: assert property (@(posedge hclk) disable iff (!hresetn)
        (filled && fall) |=> serial_out == $past(shift_stages[ROWS-2]))
        else $error("cascade out is not last stage");
    chk_cascade_still: assert property (@(posedge hclk) disable iff (!hresetn)
        (filled && $changed(serial_out)) |-> $past(fall))
        else $error("cascade out moved without a shift");
    chk_play_word: assert property (@(posedge hclk) disable iff (!hresetn)
        (st == RDSG_IDLE && fout.valid) |-> ##PLAY_CYCLES (st == RDSG_IDLE))
        else $error("fifo word did not take 32 shifts");
    chk_bits_live: assert property (@(posedge hclk) disable iff (!hresetn)
        (st != RDSG_IDLE) |-> (bits_left != 6'h00))
        else $error("playback running with no bits left");
    chk_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (ap_wr && (ap_addr == OFS_CTRL)) |=> (ctrl == $past(hwdata)))
        else $error("ctrl write did not land");
    chk_read_stages: assert property (@(posedge hclk) disable iff (!hresetn)
        (filled && take && !hwrite && (haddr[7:0] == OFS_STAGES)) |=>
        (hrdata == $past(32'(shift_stages))))
        else $error("stage read returned a wrong word");
    chk_stall_full: assert property (@(posedge hclk) disable iff (!hresetn)
        !hreadyout |-> (fifo_level == FIFO_DEPTH))
        else $error("bus stalled with fifo not full");
    chk_stall_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        !hreadyout |-> ##[1:STALL_MAX] hreadyout)
        else $error("bus stall outlasted one word of playback");
endmodule : rdsg_top

// ==== verif/rdsg_ctrl_model.sv ====
// rdsg_ctrl_model: display controller driving serial bits and gating pins
// assumes the row driver samples these pins on hclk
`timescale 1ns/1ps
module rdsg_ctrl_model (
    input  wire logic hclk,
    output logic      serial_clk,
    output logic      serial_in,
    output logic      enable,
    output logic      force_all_on_n
);
    int gap = 0;
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        enable = 1'b0;
        force_all_on_n = 1'b1;
    end
    // msb first, so the first bit sent ends in the last stage
    task automatic send(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge hclk);
            serial_in <= w[i];
            serial_clk <= 1'b1;
            @(posedge hclk);
            serial_clk <= 1'b0;
            @(posedge hclk);
            // hold time over: show a changed level, not the stale bit
            serial_in <= ~w[i];
            repeat (gap) @(posedge hclk);
        end
    endtask : send
    task automatic gate(input logic e, input logic f);
        @(posedge hclk);
        enable <= e;
        force_all_on_n <= f;
    endtask : gate
    // clock stands still low while data toggles
    task automatic stir(input int n);
        repeat (n) begin
            @(posedge hclk);
            serial_in <= ~serial_in;
        end
    endtask : stir
endmodule : rdsg_ctrl_model

// ==== verif/rdsg_top_tb.sv ====
// rdsg_top_tb: self-checking bench for rdsg_top, normal and reversed builds
// assumes one AHB-Lite master (this bench) and the controller model on the pins
`timescale 1ns/1ps
module rdsg_top_tb;
    import rdsg_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rows, rows_r, stg, w;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        serial_clk, serial_in, enable, force_all_on_n, serial_out, rd_pend, saw_stall;
    logic [31:0] qbus[$];
    logic [64:0] qpin[$];
    int          bad_count, n_checks;
    event        look;
    rdsg_ctrl_model ctrl_u (.hclk(hclk), .serial_clk(serial_clk), .serial_in(serial_in),
        .enable(enable), .force_all_on_n(force_all_on_n));
    rdsg_top #(.ROWS(32), .REVERSE(1'b0)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .serial_clk(serial_clk), .serial_in(serial_in), .enable(enable),
        .force_all_on_n(force_all_on_n), .serial_out(serial_out), .row_outputs(rows));
    // shares the bus; only its rows are watched
    rdsg_top #(.ROWS(32), .REVERSE(1'b1)) dut_rev (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
        .serial_clk(serial_clk), .serial_in(serial_in), .enable(enable),
        .force_all_on_n(force_all_on_n), .serial_out(), .row_outputs(rows_r));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0);
    endfunction : lfsr
    function automatic logic [31:0] rev(input logic [31:0] x);
        for (int i = 0; i < 32; i++) rev[i] = x[31-i];
    endfunction : rev
    task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : ahb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        qbus.push_back(e);
        ahb(a, 1'b0, 32'h0);
    endtask : rd
    // drives the gating pins and notes what the rows must show one cycle later
    task automatic pin_chk(input logic e, input logic f);
        logic [31:0] r;
        r = !f ? 32'hFFFF_FFFF : (e ? stg : 32'h0);
        ctrl_u.gate(e, f);
        qpin.push_back({stg[31], r, rev(r)});
        @(posedge hclk);
        #1;
        ->look;
    endtask : pin_chk
    always @(posedge hclk) begin
        if (hreadyout === 1'b0) saw_stall <= 1'b1;
        if (hreadyout === 1'b1) begin
            if (rd_pend) chk({33'h0, hrdata}, {33'h0, qbus.pop_front()});
            rd_pend <= hsel && htrans == HTRANS_NSEQ && !hwrite;
        end
    end
    always @(look) chk({serial_out, rows, rows_r}, qpin.pop_front());
    initial begin
        repeat (6000) @(posedge hclk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, rd_pend, saw_stall} = '0;
        hsize = 3'h2;
        bad_count = 0;
        n_checks = 0;
        w = 32'hF69A_8BE3;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_CTRL, CTRL_RESET);
        ahb(OFS_CTRL, 1'b1, 32'h0000_0003);
        rd(OFS_CTRL, 32'h0000_0003);
        rd(8'h20, 32'h0);
        for (int k = 0; k < 3; k++) begin
            w = lfsr(w);
            ctrl_u.gap = k;
            ctrl_u.send(w, 32);
            stg = w;
            rd(OFS_STAGES, stg);
            pin_chk(1'b1, 1'b1);
            pin_chk(1'b0, 1'b1);
            pin_chk(1'b0, 1'b0);
            pin_chk(1'b1, 1'b0);
        end
        ctrl_u.gate(1'b1, 1'b1);
        ctrl_u.stir(6);
        pin_chk(1'b1, 1'b1);
        ctrl_u.send(32'h1, 1);
        stg = {stg[30:0], 1'b1};
        pin_chk(1'b1, 1'b1);
        // software clock and data bits through ctrl shift in one more one
        ahb(OFS_CTRL, 1'b1, 32'h0000_000F);
        ahb(OFS_CTRL, 1'b1, 32'h0000_0007);
        ahb(OFS_CTRL, 1'b1, 32'h0000_0003);
        stg = {stg[30:0], 1'b1};
        rd(OFS_STAGES, stg);
        // words beyond the fifo depth plus the word in playback must stall the bus until playback frees a slot
        for (int k = 0; k < FIFO_DEPTH + 3; k++) begin
            w = lfsr(w);
            ahb(OFS_DATA, 1'b1, w);
        end
        stg = w;
        chk({64'h0, saw_stall}, 65'h1);
        repeat ((FIFO_DEPTH + 3) * 64 + 60) @(posedge hclk);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_STAGES, stg);
        rd(OFS_ROWS, stg);
        pin_chk(1'b1, 1'b1);
        report_and_stop();
    end
endmodule : rdsg_top_tb
